// >>> bench/spit_fetch_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==================================================
// fetch side: holds an instruction at the issue point until taken
module spit_fetch_model
(
  input wire logic clk_sys,
  input wire logic issue_pulse,
  output logic instr_valid,
  output logic [4:0] instr_class
);
  int cyc = 0;
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
  end
  initial
  begin
    instr_valid = 1'b0;
    instr_class = 5'h1f;
  end
  // valid stays up on return so the next send can follow back to back
  task automatic send(input logic [4:0] c, output int t);
    int n;
    n = 0;
    instr_valid = 1'b1;
    instr_class = c;
    @(posedge clk_sys) #1;
    while (issue_pulse !== 1'b1 && n < 40)
    begin
      @(posedge clk_sys) #1;
      n++;
    end
    t = (n >= 40) ? -1 : cyc;
  endtask
  // raise a request without waiting, for stall checks
  task automatic offer(input logic [4:0] c);
    instr_valid = 1'b1;
    instr_class = c;
  endtask
  // stale class flipped so it cannot pass for a live request
  task automatic idle();
    instr_valid = 1'b0;
    instr_class = ~instr_class;
  endtask
endmodule
`default_nettype wire

// >>> bench/spit_issue_chk.sv
`timescale 1ns/100ps
`default_nettype none
`include "spit_map.vh"
// ==================================================
// issue timing checks on the core's ports
module spit_issue_chk
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic instr_valid,
  input wire logic [4:0] instr_class,
  input wire logic instr_ready,
  input wire logic issue_pulse,
  input wire logic stall_dep,
  input wire logic stall_lat,
  input wire logic exc_redirect,
  input wire logic [6:0] exec_stage_valid,
  input wire logic [2:0] mem_stage_valid,
  input wire logic [1:0] mac_occupancy
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  a_take_needs_valid: assert property (issue_pulse |-> $past(instr_valid))
    else $error("issue with no request");
  a_stall_blocks: assert property ((stall_dep || stall_lat) |-> !issue_pulse && !instr_ready)
    else $error("issue during a stall");
  a_ready_at_take: assert property (issue_pulse |-> instr_ready)
    else $error("issue while not ready");
  a_mac_two_max: assert property (mac_occupancy <= 2'h2)
    else $error("multiply pipe over two");
  a_swap_hold: assert property ((issue_pulse && $past(instr_class) == `SPIT_CLS_SWAP) |=> !issue_pulse [*4])
    else $error("swap followed too soon");
  a_cp_load_hold: assert property ((issue_pulse && $past(instr_class) == `SPIT_CLS_CP_LD)
    |=> !issue_pulse [*8] ##1 !issue_pulse ##1 !issue_pulse)
    else $error("coprocessor load followed too soon");
  a_exc_handler: assert property ((issue_pulse && $past(instr_class) == `SPIT_CLS_EXC) |-> ##6 exc_redirect)
    else $error("handler entry off");
  a_exec_flow: assert property (exec_stage_valid[6] |-> $past(exec_stage_valid[0], 6))
    else $error("main pipe stage skipped");
  a_mem_flow: assert property (mem_stage_valid[2] |-> $past(mem_stage_valid[0], 2))
    else $error("memory pipe stage skipped");
endmodule
`default_nettype wire

// >>> bench/spit_issue_ctrl_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "spit_map.vh"
module spit_issue_ctrl_bench;
  logic clk_sys, srst, instr_valid, cmp, llk, mch, btk, mis, dv, bwb;
  logic instr_ready, issue_pulse, stall_dep, stall_lat, exc_redirect, unpredictable_pc;
  logic [4:0] instr_class;
  logic [3:0] dst, bas;
  logic [15:0] lst, src, pending_regs;
  logic [6:0] exec_stage_valid;
  logic [2:0] mem_stage_valid;
  logic [1:0] mac_occupancy;
  int num_errors = 0;
  int comparisons = 0;
  // ==================================================
  // core and fetch side
  spit_issue_ctrl spit_issue_ctrl_i
  (
    .clk_sys(clk_sys), .srst(srst), .instr_valid(instr_valid), .instr_class(instr_class),
    .compressed(cmp), .long_link_low(llk), .mode_change(mch), .branch_taken(btk),
    .mispredict(mis), .dest_reg(dst), .dest_valid(dv), .base_reg(bas), .base_wb(bwb),
    .reg_list(lst), .src_regs(src), .mul_issue_lat(6'h01), .mul_result_lat(6'h03),
    .mul_cycles(3'h3), .instr_ready(instr_ready), .issue_pulse(issue_pulse),
    .stall_dep(stall_dep), .stall_lat(stall_lat), .exc_redirect(exc_redirect),
    .exec_stage_valid(exec_stage_valid), .mem_stage_valid(mem_stage_valid),
    .mac_occupancy(mac_occupancy), .pending_regs(pending_regs), .unpredictable_pc(unpredictable_pc)
  );
  spit_fetch_model spit_fetch_model_i
  (
    .clk_sys(clk_sys), .issue_pulse(issue_pulse), .instr_valid(instr_valid), .instr_class(instr_class)
  );
  // ==================================================
  // helpers
  task automatic print_verdict();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input int seen, input int exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %0d seen %0d", nm, exp, seen);
    end
  endtask
  task automatic clr();
    {cmp, llk, mch, btk, mis, dv, bwb} = 7'h00;
    dst = 4'h0;
    bas = 4'h0;
    lst = 16'h0000;
  endtask
  // one instruction, then an alu op reading s; checks the issue distance against e
  task automatic gap(input logic [4:0] c, input logic [3:0] d, input logic [15:0] l,
    input logic [15:0] s, input int e);
    int a;
    int b;
    src = 16'h0000;
    dst = d;
    dv = d != 4'h0;
    lst = l;
    spit_fetch_model_i.send(c, a);
    clr();
    src = s;
    spit_fetch_model_i.send(`SPIT_CLS_ALU, b);
    // a lost issue counts here and again in the gap below
    if (a < 0 || b < 0)
      num_errors++;
    chk("issue gap", b - a, e);
  endtask
  // ==================================================
  // scenarios
  task automatic t_status();
    gap(`SPIT_CLS_SR_RD, 4'h0, 16'h0000, 16'h0000, 1);
    gap(`SPIT_CLS_SR_RD, 4'h2, 16'h0000, 16'h0004, 2);
    gap(`SPIT_CLS_SR_WR, 4'h0, 16'h0000, 16'h0000, 2);
    mch = 1'b1;
    gap(`SPIT_CLS_SR_WR, 4'h0, 16'h0000, 16'h0000, 6);
  endtask
  task automatic t_mem();
    gap(`SPIT_CLS_LOAD, 4'h3, 16'h0000, 16'h0008, 3);
    gap(`SPIT_CLS_LOAD, 4'h3, 16'h0000, 16'h0200, 1);
    gap(`SPIT_CLS_ALU, 4'h5, 16'h0000, 16'h0020, 1);
    gap(`SPIT_CLS_DLOAD, 4'h4, 16'h0000, 16'h0020, 4);
    gap(`SPIT_CLS_DLOAD, 4'hc, 16'h0000, 16'h0000, 2);
    gap(`SPIT_CLS_MUL, 4'h7, 16'h0000, 16'h0080, 3);
    gap(`SPIT_CLS_STORE, 4'h0, 16'h0000, 16'h0000, 1);
    gap(`SPIT_CLS_PLD, 4'h0, 16'h0000, 16'h0000, 1);
    gap(`SPIT_CLS_DSTORE, 4'h0, 16'h0000, 16'h0000, 2);
    gap(`SPIT_CLS_BLK_LD, 4'h0, 16'h000e, 16'h0000, 5);
    gap(`SPIT_CLS_BLK_LD, 4'h0, 16'h000e, 16'h0008, 7);
    gap(`SPIT_CLS_BLK_LD, 4'h0, 16'h000e, 16'h0004, 6);
    gap(`SPIT_CLS_BLK_ST, 4'h0, 16'h80f0, 16'h0000, 7);
  endtask
  task automatic t_cop();
    gap(`SPIT_CLS_SWAP, 4'h0, 16'h0000, 16'h0000, 5);
    gap(`SPIT_CLS_SC_RD, 4'h0, 16'h0000, 16'h0000, 4);
    gap(`SPIT_CLS_SC_WR, 4'h0, 16'h0000, 16'h0000, 2);
    gap(`SPIT_CLS_DBG_RD, 4'h0, 16'h0000, 16'h0000, 8);
    gap(`SPIT_CLS_DBG_RD, 4'hf, 16'h0000, 16'h0000, 9);
    gap(`SPIT_CLS_DBG_WR, 4'h0, 16'h0000, 16'h0000, 8);
    gap(`SPIT_CLS_CP_LD, 4'h0, 16'h0000, 16'h0000, 11);
    gap(`SPIT_CLS_CP_ST, 4'h0, 16'h0000, 16'h0000, 8);
  endtask
  task automatic t_branch();
    gap(`SPIT_CLS_BR_PRED, 4'h0, 16'h0000, 16'h0000, 1);
    mis = 1'b1;
    gap(`SPIT_CLS_BR_PRED, 4'h0, 16'h0000, 16'h0000, 5);
    {cmp, mis} = 2'h3;
    gap(`SPIT_CLS_BR_PRED, 4'h0, 16'h0000, 16'h0000, 6);
    btk = 1'b1;
    gap(`SPIT_CLS_BR_NPRED, 4'h0, 16'h0000, 16'h0000, 5);
    {cmp, btk} = 2'h3;
    gap(`SPIT_CLS_BR_NPRED, 4'h0, 16'h0000, 16'h0000, 6);
    cmp = 1'b1;
    gap(`SPIT_CLS_BR_NPRED, 4'h0, 16'h0000, 16'h0000, 1);
    {cmp, llk, btk} = 3'h7;
    gap(`SPIT_CLS_BR_NPRED, 4'h0, 16'h0000, 16'h0000, 1);
  endtask
  task automatic t_exc();
    int a;
    int n;
    spit_fetch_model_i.send(`SPIT_CLS_EXC, a);
    spit_fetch_model_i.idle();
    n = 0;
    while (exc_redirect !== 1'b1 && n < 20)
    begin
      @(posedge clk_sys) #1;
      n++;
    end
    chk("handler entry", n, 6);
  endtask
  // flag outputs: pc read, stalls, pending set, memory pipe, multiply occupancy
  task automatic t_flags();
    int a;
    int b;
    dst = 4'hf;
    dv = 1'b1;
    spit_fetch_model_i.send(`SPIT_CLS_SC_RD, a);
    chk("unpredictable pc", unpredictable_pc, 1);
    clr();
    src = 16'h8000;
    spit_fetch_model_i.offer(`SPIT_CLS_ALU);
    @(posedge clk_sys) #1;
    chk("dependency stall", stall_dep, 1);
    chk("latency stall", stall_lat, 1);
    chk("ready in hold", instr_ready, 0);
    chk("pending pc", pending_regs, 16'h8000);
    spit_fetch_model_i.send(`SPIT_CLS_ALU, b);
    chk("pc read gap", b - a, 4);
    src = 16'h0000;
    {bwb, bas, lst} = {1'b1, 4'h6, 16'h000e};
    spit_fetch_model_i.send(`SPIT_CLS_BLK_LD, a);
    spit_fetch_model_i.idle();
    clr();
    @(posedge clk_sys) #1;
    chk("pending block", pending_regs, 16'h004e);
    repeat (4) @(posedge clk_sys);
    #1;
    chk("memory pipe", mem_stage_valid, 3'h1);
    spit_fetch_model_i.send(`SPIT_CLS_MUL, a);
    spit_fetch_model_i.idle();
    @(posedge clk_sys) #1;
    chk("multiply occupancy", mac_occupancy, 1);
  endtask
  // ==================================================
  // run
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial
  begin
    srst = 1'b1;
    src = 16'h0000;
    clr();
    repeat (10) @(posedge clk_sys);
    #1;
    srst = 1'b0;
    t_status();
    t_mem();
    t_cop();
    t_branch();
    t_exc();
    t_flags();
    print_verdict();
  end
endmodule
bind spit_issue_ctrl spit_issue_chk spit_issue_chk_i
(
  .clk_sys(clk_sys), .srst(srst), .instr_valid(instr_valid), .instr_class(instr_class),
  .instr_ready(instr_ready), .issue_pulse(issue_pulse), .stall_dep(stall_dep),
  .stall_lat(stall_lat), .exc_redirect(exc_redirect), .exec_stage_valid(exec_stage_valid),
  .mem_stage_valid(mem_stage_valid), .mac_occupancy(mac_occupancy)
);
`default_nettype wire

// >>> src/spit_issue_ctrl.v
// Overview of operation
// - status read 1/2; write 2 or 6/1
// - loads issue 1, data 3, base 1
// - doubleword load 1(+1 reg twelve), 3/4; base writeback leaves the second register unscoreboarded
// - stores 1, doubleword store 2, base same
// - block load 2+n; results 4+n,3+n,2+n
// - block store 2+n; base usable 2+n
// - swaps issue and result 5
// - system coproc read 4/4, write 2
// - debug coproc 8, 9 to pc, load 11
// - exceptions reach handler after 6 cycles
// - compressed predicted mispredict 6 not 5
// - compressed unpredicted taken branch plus one
// - compressed long link first half as alu
// - one in-order issue per cycle
// - seven stage main execution path
// - mispredict costs four cycles
// - decode plus register read two cycles
// - memory three stages, multiply five stages
// - younger short results may finish first
// - scoreboard loads, multiplies, swaps, status and coprocessor reads, base writeback
// - no dependency means no dependency stall
// - forward results from several sources
// - at most two in multiply pipe
`timescale 1ns/100ps
`default_nettype none
`include "spit_map.vh"
module spit_issue_ctrl
#(
  parameter NREG = 16
)
(
  input wire clk_sys,
  input wire srst,
  input wire instr_valid,
  input wire [4:0] instr_class,
  input wire compressed,
  input wire long_link_low,
  input wire mode_change,
  input wire branch_taken,
  input wire mispredict,
  input wire [3:0] dest_reg,
  input wire dest_valid,
  input wire [3:0] base_reg,
  input wire base_wb,
  input wire [15:0] reg_list,
  input wire [15:0] src_regs,
  input wire [5:0] mul_issue_lat,
  input wire [5:0] mul_result_lat,
  input wire [2:0] mul_cycles,
  output reg instr_ready,
  output reg issue_pulse,
  output reg stall_dep,
  output reg stall_lat,
  output reg exc_redirect,
  output reg [6:0] exec_stage_valid,
  output reg [2:0] mem_stage_valid,
  output reg [1:0] mac_occupancy,
  output reg [NREG-1:0] pending_regs,
  output reg unpredictable_pc
);
  // ==================================================
  // state
  localparam ST_RUN = 1'b0;
  localparam ST_HOLD = 1'b1;
  reg state_r;
  reg [5:0] hold_r;
  reg [5:0] exc_cnt_r;
  reg [2:0] mac_rem_a_r;
  reg [2:0] mac_rem_b_r;
  reg [4:0] mem_pipe_r;
  wire [5:0] numreg;
  wire [NREG-1:0] busy;
  // ==================================================
  // last and second to last listed register of a block list
  function [3:0] top_reg;
    input [15:0] lst;
    input skip;
    integer k;
    reg seen;
    begin
      top_reg = 4'h0;
      seen = 1'b0;
      for (k = 0; k < 16; k = k + 1)
        if (lst[k])
        begin
          if (!skip || seen)
            top_reg = k[3:0];
          seen = 1'b1;
        end
      if (skip)
      begin
        seen = 1'b0;
        for (k = 15; k >= 0; k = k - 1)
          if (lst[k] && k[3:0] != top_reg_hi(lst) && !seen)
          begin
            top_reg = k[3:0];
            seen = 1'b1;
          end
      end
    end
  endfunction
  function [3:0] top_reg_hi;
    input [15:0] lst;
    integer j;
    begin
      top_reg_hi = 4'h0;
      for (j = 0; j < 16; j = j + 1)
        if (lst[j])
          top_reg_hi = j[3:0];
    end
  endfunction

  spit_popcount u_cnt
  (
    .reg_list(reg_list),
    .count(numreg)
  );

  // ==================================================
  // latency decode
  reg [5:0] iss_lat;
  reg [5:0] res_lat;
  reg [5:0] res2_lat;
  reg [5:0] base_lat;
  reg res_track;
  reg res2_track;
  reg is_block_ld;
  reg is_mul;
  reg is_mem;
  always @*
  begin
    iss_lat = `SPIT_ONE;
    res_lat = `SPIT_ONE;
    res2_lat = `SPIT_ONE;
    base_lat = `SPIT_ONE;
    res_track = 1'b0;
    res2_track = 1'b0;
    is_block_ld = 1'b0;
    is_mul = 1'b0;
    case (instr_class)
      `SPIT_CLS_SR_RD:
      begin
        res_lat = `SPIT_SR_RD_RES;
        res_track = 1'b1;
      end
      `SPIT_CLS_SR_WR:
        iss_lat = mode_change ? `SPIT_SR_WR_MODE_ISS : `SPIT_SR_WR_ISS;
      `SPIT_CLS_LOAD:
      begin
        res_lat = `SPIT_LD_RES;
        res_track = 1'b1;
      end
      `SPIT_CLS_DLOAD:
      begin
        iss_lat = (dest_reg == `SPIT_REG_TWELVE) ? `SPIT_DST_ISS : `SPIT_ONE;
        base_lat = iss_lat;
        res_lat = `SPIT_LD_RES;
        res2_lat = `SPIT_DLD_RES2;
        res_track = 1'b1;
        res2_track = 1'b1;
      end
      `SPIT_CLS_STORE, `SPIT_CLS_PLD:
        iss_lat = `SPIT_ONE;
      `SPIT_CLS_DSTORE:
      begin
        iss_lat = `SPIT_DST_ISS;
        base_lat = `SPIT_DST_ISS;
      end
      `SPIT_CLS_BLK_LD:
      begin
        iss_lat = `SPIT_BLK_BASE + numreg;
        base_lat = `SPIT_BLK_BASE + numreg;
        is_block_ld = 1'b1;
      end
      `SPIT_CLS_BLK_ST:
      begin
        iss_lat = `SPIT_BLK_BASE + numreg;
        base_lat = `SPIT_BLK_BASE + numreg;
      end
      `SPIT_CLS_SWAP:
      begin
        iss_lat = `SPIT_SWAP_LAT;
        res_lat = `SPIT_SWAP_LAT;
        res_track = 1'b1;
      end
      `SPIT_CLS_SC_RD:
      begin
        iss_lat = `SPIT_SC_RD_LAT;
        res_lat = `SPIT_SC_RD_LAT;
        res_track = 1'b1;
      end
      `SPIT_CLS_SC_WR:
        iss_lat = `SPIT_SC_WR_ISS;
      `SPIT_CLS_DBG_RD:
      begin
        iss_lat = (dest_reg == `SPIT_PC_REG) ? `SPIT_DBG_PC_LAT : `SPIT_DBG_LAT;
        res_lat = iss_lat;
        res_track = 1'b1;
      end
      `SPIT_CLS_DBG_WR, `SPIT_CLS_CP_ST:
        iss_lat = `SPIT_DBG_LAT;
      `SPIT_CLS_CP_LD:
        iss_lat = `SPIT_CP_LD_ISS;
      `SPIT_CLS_EXC:
        iss_lat = `SPIT_EXC_LAT;
      `SPIT_CLS_BR_PRED:
        // mispredicted: base 1 plus the 4-cycle penalty, one more when compressed
        iss_lat = mispredict ? (`SPIT_BR_PRED_MISP + {5'h00, compressed}) : `SPIT_ONE;
      `SPIT_CLS_BR_NPRED:
        iss_lat = branch_taken ? (`SPIT_BR_PRED_MISP + {5'h00, compressed}) : `SPIT_ONE;
      `SPIT_CLS_MUL:
      begin
        iss_lat = mul_issue_lat;
        res_lat = mul_result_lat;
        res_track = 1'b1;
        is_mul = 1'b1;
      end
      default:
      begin
        // alu results forward next cycle, never scoreboarded; also the low long-link half
        iss_lat = `SPIT_ONE;
      end
    endcase
    if (long_link_low && compressed)
    begin
      iss_lat = `SPIT_ONE;
      res_track = 1'b0;
    end
    if (iss_lat == 6'h00)
      iss_lat = `SPIT_ONE;
    // only loads, stores, swaps and coprocessor loads and stores reach the data cache
    is_mem = ((instr_class >= `SPIT_CLS_LOAD) && (instr_class <= `SPIT_CLS_SWAP)) ||
      (instr_class == `SPIT_CLS_CP_LD) || (instr_class == `SPIT_CLS_CP_ST);
  end

  // ==================================================
  // hazards: pending load, multiply, swap, status and coprocessor read destinations and base writebacks stall
  wire dep_hit = |(src_regs & busy);
  wire mac_full = (mac_rem_a_r != 3'h0) && !(mac_rem_a_r == 3'h1 && mac_rem_b_r == 3'h0);
  // hold_r counts the edges still closed to a take
  wire lat_wait = (state_r == ST_HOLD) && (hold_r != 6'h00);
  wire can_issue = !lat_wait && !dep_hit && !(is_mul && mac_full);
  wire fire = instr_valid && can_issue;

  spit_scoreboard #(.NREG(NREG)) u_sb
  (
    .clk_sys(clk_sys),
    .srst(srst),
    .set_a(fire && res_track && dest_valid),
    .set_a_reg(dest_reg),
    .set_a_lat(res_lat),
    .set_b(fire && ((res2_track && dest_valid) || base_wb)),
    .set_b_reg(res2_track && dest_valid && !base_wb ? dest_reg + 4'h1 : base_reg),
    .set_b_lat(res2_track && dest_valid && !base_wb ? res2_lat : base_lat),
    .block_mask(fire && is_block_ld ? reg_list : 16'h0000),
    .block_lat(`SPIT_BLK_BASE + numreg),
    .block_pen_lat(`SPIT_BLK_PEN + numreg),
    .block_last_lat(`SPIT_BLK_LAST + numreg),
    .block_pen_reg(top_reg(reg_list, 1'b1)),
    .block_last_reg(top_reg_hi(reg_list)),
    .busy(busy)
  );

  // ==================================================
  // issue sequencer
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      state_r <= ST_RUN;
      hold_r <= 6'h00;
    end
    else
    begin
      case (state_r)
        ST_RUN:
          if (fire && iss_lat > `SPIT_ONE)
          begin
            state_r <= ST_HOLD;
            hold_r <= iss_lat - `SPIT_ONE;
          end
        ST_HOLD:
          if (hold_r > `SPIT_ONE)
            hold_r <= hold_r - `SPIT_ONE;
          else
          begin
            // last closed edge: no take can coincide, so no reload here
            state_r <= ST_RUN;
            hold_r <= 6'h00;
          end
        default:
          state_r <= ST_RUN;
      endcase
    end
  end

  // ==================================================
  // exception redirect, multiply and stage tracking
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      exc_cnt_r <= 6'h00;
      mac_rem_a_r <= 3'h0;
      mac_rem_b_r <= 3'h0;
      exc_redirect <= 1'b0;
      exec_stage_valid <= 7'h00;
      mem_stage_valid <= 3'h0;
      mem_pipe_r <= 5'h00;
      mac_occupancy <= 2'h0;
      instr_ready <= 1'b0;
      issue_pulse <= 1'b0;
      stall_dep <= 1'b0;
      stall_lat <= 1'b0;
      pending_regs <= {NREG{1'b0}};
      unpredictable_pc <= 1'b0;
    end
    else
    begin
      if (fire && instr_class == `SPIT_CLS_EXC)
        // redirect registers off count 1, so it lands on the sixth edge
        exc_cnt_r <= `SPIT_EXC_LAT;
      else if (exc_cnt_r != 6'h00)
        exc_cnt_r <= exc_cnt_r - `SPIT_ONE;
      exc_redirect <= (exc_cnt_r == `SPIT_ONE);
      // two-slot multiply tracking; a new entry only while slot a is empty or its entry leaves with slot b empty
      if (fire && is_mul)
      begin
        mac_rem_b_r <= (mac_rem_a_r > 3'h1) ? mac_rem_a_r - 3'h1 : 3'h0;
        mac_rem_a_r <= (mul_cycles > `SPIT_MAC_STAGES) ? `SPIT_MAC_STAGES : mul_cycles;
      end
      else
      begin
        mac_rem_a_r <= (mac_rem_a_r != 3'h0) ? mac_rem_a_r - 3'h1 : 3'h0;
        mac_rem_b_r <= (mac_rem_b_r != 3'h0) ? mac_rem_b_r - 3'h1 : 3'h0;
      end
      mac_occupancy <= {1'b0, mac_rem_a_r != 3'h0} + {1'b0, mac_rem_b_r != 3'h0};
      // fetch(2), decode, operand read, alu, state, writeback; stage 0 fills on the issue edge of each non-multiply
      exec_stage_valid <= {exec_stage_valid[5:0], fire && !is_mul};
      // memory ops leave the alu stage into the cache stages
      mem_pipe_r <= {mem_pipe_r[3:0], fire && is_mem};
      mem_stage_valid <= {mem_stage_valid[1:0], mem_pipe_r[4]};
      instr_ready <= can_issue;
      issue_pulse <= fire;
      stall_dep <= instr_valid && dep_hit;
      stall_lat <= instr_valid && (lat_wait || (is_mul && mac_full));
      pending_regs <= busy;
      unpredictable_pc <= fire && instr_class == `SPIT_CLS_SC_RD && dest_reg == `SPIT_PC_REG;
    end
  end
endmodule
`default_nettype wire

// >>> src/spit_map.vh
`ifndef SPIT_MAP_VH
`define SPIT_MAP_VH
// ==================================================
// instruction classes
`define SPIT_CLS_W 5
`define SPIT_CLS_ALU 5'h00
`define SPIT_CLS_SR_RD 5'h01
`define SPIT_CLS_SR_WR 5'h02
`define SPIT_CLS_LOAD 5'h03
`define SPIT_CLS_DLOAD 5'h04
`define SPIT_CLS_STORE 5'h05
`define SPIT_CLS_DSTORE 5'h06
`define SPIT_CLS_PLD 5'h07
`define SPIT_CLS_BLK_LD 5'h08
`define SPIT_CLS_BLK_ST 5'h09
`define SPIT_CLS_SWAP 5'h0a
`define SPIT_CLS_SC_RD 5'h0b
`define SPIT_CLS_SC_WR 5'h0c
`define SPIT_CLS_DBG_RD 5'h0d
`define SPIT_CLS_DBG_WR 5'h0e
`define SPIT_CLS_CP_LD 5'h0f
`define SPIT_CLS_CP_ST 5'h10
`define SPIT_CLS_EXC 5'h11
`define SPIT_CLS_BR_PRED 5'h12
`define SPIT_CLS_BR_NPRED 5'h13
`define SPIT_CLS_MUL 5'h14
// ==================================================
// latencies in cycles, register numbers and multiply stage count
`define SPIT_LAT_W 6
`define SPIT_SR_RD_RES 6'h02
`define SPIT_SR_WR_ISS 6'h02
`define SPIT_SR_WR_MODE_ISS 6'h06
`define SPIT_LD_RES 6'h03
`define SPIT_DLD_RES2 6'h04
`define SPIT_DST_ISS 6'h02
`define SPIT_BLK_BASE 6'h02
`define SPIT_BLK_LAST 6'h04
`define SPIT_BLK_PEN 6'h03
`define SPIT_SWAP_LAT 6'h05
`define SPIT_SC_RD_LAT 6'h04
`define SPIT_SC_WR_ISS 6'h02
`define SPIT_DBG_LAT 6'h08
`define SPIT_DBG_PC_LAT 6'h09
`define SPIT_CP_LD_ISS 6'h0b
`define SPIT_EXC_LAT 6'h06
`define SPIT_MISP_PEN 6'h04
`define SPIT_BR_PRED_MISP 6'h05
`define SPIT_ONE 6'h01
`define SPIT_REG_TWELVE 4'hc
`define SPIT_PC_REG 4'hf
`define SPIT_MAC_STAGES 3'h5
`endif

// >>> src/spit_popcount.v
`timescale 1ns/100ps
`default_nettype none
`include "spit_map.vh"
// ==================================================
// register list count for block transfers
module spit_popcount
(
  input wire [15:0] reg_list,
  output reg [5:0] count
);
  integer i;
  always @*
  begin
    count = 6'h00;
    for (i = 0; i < 16; i = i + 1)
      count = count + {5'h00, reg_list[i]};
  end
endmodule
`default_nettype wire

// >>> src/spit_scoreboard.v
`timescale 1ns/100ps
`default_nettype none
`include "spit_map.vh"
// ==================================================
// per-register pending counters for load, multiply, swap, status and coprocessor read destinations and base writebacks
module spit_scoreboard
#(
  parameter NREG = 16
)
(
  input wire clk_sys,
  input wire srst,
  input wire set_a,
  input wire [3:0] set_a_reg,
  input wire [5:0] set_a_lat,
  input wire set_b,
  input wire [3:0] set_b_reg,
  input wire [5:0] set_b_lat,
  input wire [15:0] block_mask,
  input wire [5:0] block_lat,
  input wire [5:0] block_pen_lat,
  input wire [5:0] block_last_lat,
  input wire [3:0] block_pen_reg,
  input wire [3:0] block_last_reg,
  output wire [NREG-1:0] busy
);
  genvar g;
  generate
    for (g = 0; g < NREG; g = g + 1)
    begin : gen_reg
      // genvar held as a sized constant: a part-select of a genvar is not legal
      localparam [3:0] RIDX = g;
      reg [5:0] cnt_r;
      reg [5:0] cnt_nxt;
      // result usable when counter reaches 1: forwarded in that issue slot
      assign busy[g] = (cnt_r > `SPIT_ONE);
      always @*
      begin
        cnt_nxt = (cnt_r != 6'h00) ? cnt_r - `SPIT_ONE : 6'h00;
        if (block_mask[g])
        begin
          if (block_last_reg == RIDX)
            cnt_nxt = block_last_lat;
          else if (block_pen_reg == RIDX)
            cnt_nxt = block_pen_lat;
          else
            cnt_nxt = block_lat;
        end
        if (set_a && set_a_reg == RIDX)
          cnt_nxt = set_a_lat;
        if (set_b && set_b_reg == RIDX)
          cnt_nxt = set_b_lat;
      end
      always @(posedge clk_sys)
      begin
        if (srst)
          cnt_r <= 6'h00;
        else
          cnt_r <= cnt_nxt;
      end
    end
  endgenerate
endmodule
`default_nettype wire
